// ==== hw/stir_core.sv ====
// Functional notes
// - eleven-bit run_test_control shifts between tdi and tdo under control-scan codes
// - capture-dr leaves the run_test_control shift stage untouched
// - power-up or test-logic-reset sets run_test_control to 00000000010
// - tdi enters bit 10, bit 0 is presented at tdo
// - bits 10..3 mask inputs 8..1, bits 2..0 hold the op code
// - single-stage bypass path loads 0 in capture-dr
// - opcodes are eight bits, bit 7 gives even parity
// - extest codes 00000011 or 00000000 select chain, capture pins, test mode
// - bypass and every unlisted opcode select bypass, capture 0, normal mode
// - sample/preload 10000010 selects chain, captures pins, normal mode
// - highz 00000110 selects bypass and floats every bidirectional pin
// - clamp 10000111 selects bypass and enters test mode
// - run-test 00001001 selects bypass, test mode, runs op in run-test/idle
// - five run-test operations are decoded from the op code
// - read codes select chain, hold contents; 00001010 normal, 10001011 test
// - cell self-check 00001100 captures inverted cells, normal mode
// - toggle-outputs 10001101 selects bypass, toggles outputs in run-test/idle
// - while toggling, input cells hold and ignore the input pins
// - control-scan codes hold in capture-dr; 10001110 normal, 00001111 test
// - instruction captures 10000001, resets to bypass, updates in update-ir
// - op code X00 toggle, X01 pseudorandom_pattern_gen, X10 psa, 011 psa+pseudorandom_pattern_gen, 111 psa+count
// - run-test only with exactly one direction enabled, otherwise bypass
// - mask flag 1 excludes the matching input from signature compression
`timescale 1ns/1ps
module stir_core import stir_pkg::*; (
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic reset, // async reset, active high
    input wire logic tck, // test clock pin
    input wire logic tms, // test mode select pin
    input wire logic tdi, // test data in pin
    input wire logic chain_so, // serial out of the boundary chain
    input wire logic a_side_drive_enable, // a-side output enable cell
    input wire logic b_side_drive_enable, // b-side output enable cell
    output logic tdo, // test data out
    output logic tdo_oe, // tdo drive enable, high while driving
    output stir_ctl_t ctl, // decoded instruction for the chain
    output stir_strobe_t strobe // tck-edge strobes for the chain
);

    // all state of the block except the controller tracker in one record
    typedef struct packed {
        logic tck_m;
        logic tms_m;
        logic tdi_m;
        logic tck_s;
        logic tms_s;
        logic tdi_s;
        logic tck_p;
        logic [IR_W-1:0] ir_shift;
        logic [IR_W-1:0] ir_cur;
        logic [RTC_W-1:0] rtc_shift;
        logic [RTC_W-1:0] rtc_cur;
        logic bypass_stage;
        logic tdo_bit;
        logic tdo_en;
        stir_ctl_t ctl_cur;
    } stir_core_st_t;

    // controls of the bypass instruction
    localparam stir_ctl_t CTL_RESET = '{
        boundary_sel: 1'b0,
        bypass_sel: 1'b1,
        ctrl_sel: 1'b0,
        test_mode: 1'b0,
        highz: 1'b0,
        run_active: 1'b0,
        toggle_active: 1'b0,
        cap_mode: CAP_HOLD,
        run_op: OP_PSA16,
        input_mask: '0
    };

    // pins rest with mode select and data high
    localparam stir_core_st_t ST_RESET = '{
        tck_m: 1'b0,
        tms_m: 1'b1,
        tdi_m: 1'b1,
        tck_s: 1'b0,
        tms_s: 1'b1,
        tdi_s: 1'b1,
        tck_p: 1'b0,
        ir_shift: IR_RESET,
        ir_cur: IR_RESET,
        rtc_shift: RTC_RESET,
        rtc_cur: RTC_RESET,
        bypass_stage: 1'b0,
        tdo_bit: 1'b0,
        tdo_en: 1'b0,
        ctl_cur: CTL_RESET
    };

    // block state, its next value and the tracker state
    stir_core_st_t st_q;
    stir_core_st_t st_d;
    stir_tap_t tap_state;
    logic tck_rise;
    logic tck_fall;

    // op code field to run-test operation
    function automatic stir_op_t decode_op(input logic [OP_W-1:0] code);
        stir_op_t op;
        op = OP_SAMPLE_TOGGLE;
        casez (code)
            3'b?00: op = OP_SAMPLE_TOGGLE;
            3'b?01: op = OP_PRPG16;
            3'b?10: op = OP_PSA16;
            3'b011: op = OP_PSA_PRPG8;
            3'b111: op = OP_PSA_COUNT8;
            default: op = OP_SAMPLE_TOGGLE;
        endcase
        return op;
    endfunction

    // run-test/idle with a run or toggle instruction
    function automatic logic in_run_phase(input stir_tap_t s, input stir_ctl_t c);
        return (s == TAP_IDLE) & (c.run_active | c.toggle_active);
    endfunction

    // instruction plus run_test_control to the chain controls
    function automatic stir_ctl_t decode_instr(
        input logic [IR_W-1:0] ir,
        input logic [RTC_W-1:0] rtc,
        input logic a_en,
        input logic b_en
    );
        stir_ctl_t c;
        logic one_dir;
        c = CTL_RESET;
        one_dir = a_en ^ b_en;
        // exact 8-bit match: odd-parity or unlisted codes fall to bypass
        case (ir)
            OPC_EXTEST_ZERO, OPC_EXTEST: begin
                // chain drives core and pins, captures pins and core outputs
                c.bypass_sel = 1'b0;
                c.boundary_sel = 1'b1;
                c.test_mode = 1'b1;
                c.cap_mode = CAP_PINS;
            end

            // sample/preload: chain selected, core runs on
            OPC_SAMPLE: begin
                c.bypass_sel = 1'b0;
                c.boundary_sel = 1'b1;
                c.cap_mode = CAP_PINS;
            end

            // highz: bypass, pins float, core still runs
            OPC_HIGHZ: begin
                c.highz = 1'b1;
            end

            // clamp: bypass, cells drive core and pins
            OPC_CLAMP: begin
                c.test_mode = 1'b1;
            end

            // run-test: bypass, op comes from the control word
            OPC_RUN_TEST: begin
                // with both enables equal the device acts as in bypass
                if (one_dir) begin
                    c.test_mode = 1'b1;
                    c.run_active = 1'b1;
                end
            end

            // boundary read: chain holds in capture
            OPC_READ_NORMAL, OPC_READ_TEST: begin
                c.bypass_sel = 1'b0;
                c.boundary_sel = 1'b1;
                c.cap_mode = CAP_HOLD;
                c.test_mode = (ir == OPC_READ_TEST);
            end

            // self check: cells capture their inverse
            OPC_CELL_CHECK: begin
                c.bypass_sel = 1'b0;
                c.boundary_sel = 1'b1;
                c.cap_mode = CAP_INVERT;
            end

            // toggle outputs: bypass, run strobes drive the chain
            OPC_TOGGLE_OUT: begin
                // input cells hold: the chain is told not to sample pins
                c.test_mode = 1'b1;
                c.toggle_active = 1'b1;
                c.run_op = OP_SAMPLE_TOGGLE;
            end

            // control scan: run_test_control in the path
            OPC_CTRL_NORMAL, OPC_CTRL_TEST: begin
                c.bypass_sel = 1'b0;
                c.ctrl_sel = 1'b1;
                c.test_mode = (ir == OPC_CTRL_TEST);
            end

            // bypass and every unlisted or odd-parity code
            default: begin
                c.bypass_sel = 1'b1;
            end
        endcase
        if (!c.toggle_active) begin
            c.run_op = decode_op(rtc[RTC_OP_MSB:RTC_OP_LSB]);
        end
        // mask of 1 drops that input of the active direction from compression
        c.input_mask = rtc[RTC_MASK_MSB:RTC_MASK_LSB];
        return c;
    endfunction

    // controller state tracker, stepped on rising tck
    stir_tap u_tap (
        .sys_clk(sys_clk),
        .reset(reset),
        .tck_rise(tck_rise),
        .tms(st_q.tms_s),
        .state(tap_state)
    );

    // tck edges found from the synchronised copy and its delay
    assign tck_rise = st_q.tck_s & ~st_q.tck_p;
    assign tck_fall = ~st_q.tck_s & st_q.tck_p;

    // next-state logic for pins, shift stages, shadows and tdo
    always_comb begin
        st_d = st_q;

        // two-stage synchronisers, first stage only feeds the second
        st_d.tck_m = tck;
        st_d.tms_m = tms;
        st_d.tdi_m = tdi;
        st_d.tck_s = st_q.tck_m;
        st_d.tms_s = st_q.tms_m;
        st_d.tdi_s = st_q.tdi_m;
        st_d.tck_p = st_q.tck_s;

        // rising tck: capture and shift in the state being left
        if (tck_rise) begin
            case (tap_state)
                // fixed status word for the controller to inspect
                TAP_CAP_IR: begin
                    st_d.ir_shift = IR_CAPTURE;
                end
                // instruction bits enter at the top
                TAP_SHIFT_IR: begin
                    st_d.ir_shift = {st_q.tdi_s, st_q.ir_shift[IR_W-1:1]};
                end
                TAP_CAP_DR: begin
                    // run_test_control shift stage keeps its value here
                    if (st_q.ctl_cur.bypass_sel) begin
                        st_d.bypass_stage = 1'b0;
                    end
                end
                // selected data stage takes tdi
                TAP_SHIFT_DR: begin
                    if (st_q.ctl_cur.bypass_sel) begin
                        st_d.bypass_stage = st_q.tdi_s;
                    end
                    if (st_q.ctl_cur.ctrl_sel) begin
                        st_d.rtc_shift = {st_q.tdi_s, st_q.rtc_shift[RTC_W-1:1]};
                    end
                end
                default: begin
                    st_d.bypass_stage = st_q.bypass_stage;
                end
            endcase
        end

        // falling tck: tdo changes and shadows update
        if (tck_fall) begin
            st_d.tdo_en = 1'b0;
            case (tap_state)
                // instruction lsb first out
                TAP_SHIFT_IR: begin
                    st_d.tdo_bit = st_q.ir_shift[0];
                    st_d.tdo_en = 1'b1;
                end
                // tdo from the selected data register
                TAP_SHIFT_DR: begin
                    st_d.tdo_en = 1'b1;
                    if (st_q.ctl_cur.ctrl_sel) begin
                        st_d.tdo_bit = st_q.rtc_shift[0];
                    end else if (st_q.ctl_cur.boundary_sel) begin
                        st_d.tdo_bit = chain_so;
                    end else begin
                        st_d.tdo_bit = st_q.bypass_stage;
                    end
                end
                // new instruction takes effect here
                TAP_UPD_IR: begin
                    st_d.ir_cur = st_q.ir_shift;
                end
                // shadow copies the shift stage
                TAP_UPD_DR: begin
                    if (st_q.ctl_cur.ctrl_sel) begin
                        st_d.rtc_cur = st_q.rtc_shift;
                    end
                end
                default: begin
                    st_d.tdo_bit = st_q.tdo_bit;
                end
            endcase
        end

        // test-logic-reset returns instruction and control to defaults
        // reloaded each cycle there, so a tms-only reset suffices
        if (tap_state == TAP_RESET) begin
            st_d.ir_cur = IR_RESET;
            st_d.ir_shift = IR_RESET;
            st_d.rtc_cur = RTC_RESET;
            st_d.rtc_shift = RTC_RESET;
            st_d.tdo_en = 1'b0;
        end

        // decoded controls follow the instruction shadow
        st_d.ctl_cur = decode_instr(st_q.ir_cur, st_q.rtc_cur,
            a_side_drive_enable, b_side_drive_enable);
    end

    // single register for the whole block, the controller tracker keeps its own
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // registered outputs
    assign tdo = st_q.tdo_bit;
    assign tdo_oe = st_q.tdo_en;
    assign ctl = st_q.ctl_cur;

    // strobes for the boundary chain, edge strobes one sys_clk wide, logic_reset held through test-logic-reset
    always_comb begin
        strobe.logic_reset = (tap_state == TAP_RESET);
        strobe.capture_dr = tck_rise & (tap_state == TAP_CAP_DR);
        strobe.shift_dr = tck_rise & (tap_state == TAP_SHIFT_DR);
        strobe.update_dr = tck_fall & (tap_state == TAP_UPD_DR);
        // run-test and toggle act only in run-test/idle
        strobe.run_tick = tck_rise & in_run_phase(tap_state, st_q.ctl_cur);
        strobe.run_update = tck_fall & in_run_phase(tap_state, st_q.ctl_cur);
        strobe.chain_tdi = st_q.tdi_s;
    end

endmodule

// ==== hw/stir_pkg.sv ====
// shared constants and types for the scan instruction and test register block
package stir_pkg;

    // register widths
    localparam int IR_W = 8;
    localparam int RTC_W = 11;
    localparam int MASK_W = 8;
    localparam int OP_W = 3;

    // run_test_control field positions
    localparam int RTC_MASK_MSB = 10;
    localparam int RTC_MASK_LSB = 3;
    localparam int RTC_OP_MSB = 2;
    localparam int RTC_OP_LSB = 0;

    // reset and capture values
    localparam logic [RTC_W-1:0] RTC_RESET = 11'h002;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
    localparam logic [IR_W-1:0] IR_RESET = 8'hff;

    // instruction opcodes, bit 7 keeps even parity
    localparam logic [IR_W-1:0] OPC_EXTEST_ZERO = 8'h00;
    localparam logic [IR_W-1:0] OPC_BYPASS = 8'h81;
    localparam logic [IR_W-1:0] OPC_SAMPLE = 8'h82;
    localparam logic [IR_W-1:0] OPC_EXTEST = 8'h03;
    localparam logic [IR_W-1:0] OPC_HIGHZ = 8'h06;
    localparam logic [IR_W-1:0] OPC_CLAMP = 8'h87;
    localparam logic [IR_W-1:0] OPC_RUN_TEST = 8'h09;
    localparam logic [IR_W-1:0] OPC_READ_NORMAL = 8'h0a;
    localparam logic [IR_W-1:0] OPC_READ_TEST = 8'h8b;
    localparam logic [IR_W-1:0] OPC_CELL_CHECK = 8'h0c;
    localparam logic [IR_W-1:0] OPC_TOGGLE_OUT = 8'h8d;
    localparam logic [IR_W-1:0] OPC_CTRL_NORMAL = 8'h8e;
    localparam logic [IR_W-1:0] OPC_CTRL_TEST = 8'h0f;

    // test access port controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc, TAP_PAUSE_IR = 4'hd, TAP_EXIT2_IR = 4'he, TAP_UPD_IR = 4'hf
    } stir_tap_t;

    // run-test operations decoded from the op code field
    typedef enum logic [2:0] {
        OP_SAMPLE_TOGGLE = 3'h0,
        OP_PRPG16 = 3'h1,
        OP_PSA16 = 3'h2,
        OP_PSA_PRPG8 = 3'h3,
        OP_PSA_COUNT8 = 3'h4
    } stir_op_t;

    // what the boundary chain loads in capture-dr
    typedef enum logic [1:0] {
        CAP_HOLD = 2'h0,
        CAP_PINS = 2'h1,
        CAP_INVERT = 2'h2
    } stir_cap_t;

    // decoded instruction handed to the boundary chain
    typedef struct packed {
        logic boundary_sel;
        logic bypass_sel;
        logic ctrl_sel;
        logic test_mode;
        logic highz;
        logic run_active;
        logic toggle_active;
        stir_cap_t cap_mode;
        stir_op_t run_op;
        logic [MASK_W-1:0] input_mask;
    } stir_ctl_t;

    // tck-edge strobes for the boundary chain
    typedef struct packed {
        logic logic_reset;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
        logic run_tick;
        logic run_update;
        logic chain_tdi;
    } stir_strobe_t;

endpackage

// ==== hw/stir_tap.sv ====
`timescale 1ns/1ps
module stir_tap import stir_pkg::*; (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic tck_rise, // one-cycle pulse on a tck rising edge
    input wire logic tms, // synchronised mode select
    output stir_tap_t state // present controller state
);

    typedef struct packed {
        stir_tap_t tap;
    } stir_tap_st_t;

    stir_tap_st_t st_q;
    stir_tap_st_t st_d;

    // advance the controller on each rising tck edge
    always_comb begin
        st_d = st_q;
        if (tck_rise) begin
            case (st_q.tap)
                TAP_RESET: st_d.tap = tms ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: st_d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: st_d.tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: st_d.tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR: st_d.tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR: st_d.tap = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
                TAP_PAUSE_DR: st_d.tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR: st_d.tap = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
                TAP_UPD_DR: st_d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: st_d.tap = tms ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: st_d.tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR: st_d.tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR: st_d.tap = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
                TAP_PAUSE_IR: st_d.tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR: st_d.tap = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
                TAP_UPD_IR: st_d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
                default: st_d.tap = TAP_RESET;
            endcase
        end
    end

    // state register, power-up lands in test-logic-reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q <= '{tap: TAP_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign state = st_q.tap;

endmodule

// ==== dv/stir_core_sva.sv ====
`timescale 1ns/1ps
module stir_core_sva import stir_pkg::*; (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset
    input wire logic tck, // test clock pin
    input wire logic tms, // mode select pin
    input wire logic tdi, // data in pin
    input wire logic chain_so, // chain serial out
    input wire logic a_side_drive_enable, // a-side enable
    input wire logic b_side_drive_enable, // b-side enable
    input wire logic tdo, // data out
    input wire logic tdo_oe, // data out enable
    input wire stir_ctl_t ctl, // decoded instruction
    input wire stir_strobe_t strobe // chain strobes
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // capture is one pulse with no shift beside it
    sequence cap_pulse;
        strobe.capture_dr && !strobe.shift_dr ##1 !strobe.capture_dr;
    endsequence

    // instruction decode relations
    tlr_bypass_a: assert property (
        strobe.logic_reset [*3] |-> ctl.bypass_sel && !ctl.test_mode
        && ctl.run_op == OP_PSA16 && ctl.input_mask == 8'h00)
        else $error("reset state not bypass");
    one_path_a: assert property (
        $onehot({ctl.boundary_sel, ctl.bypass_sel, ctl.ctrl_sel}))
        else $error("scan path not unique");
    highz_float_a: assert property (
        ctl.highz |-> ctl.bypass_sel && !ctl.test_mode && !ctl.run_active)
        else $error("highz decode wrong");
    run_dir_a: assert property (
        ctl.run_active |-> ctl.bypass_sel && ctl.test_mode
        && $past(a_side_drive_enable) != $past(b_side_drive_enable))
        else $error("run test without one direction");
    toggle_mode_a: assert property (
        ctl.toggle_active |-> ctl.bypass_sel && ctl.test_mode
        && ctl.run_op == OP_SAMPLE_TOGGLE)
        else $error("toggle decode wrong");
    ctrl_scan_a: assert property (
        ctl.ctrl_sel |-> !ctl.highz && !ctl.run_active && !ctl.toggle_active)
        else $error("control scan decode wrong");
    // strobe and pin timing relations
    tick_cause_a: assert property (
        strobe.run_tick || strobe.run_update |-> ctl.run_active || ctl.toggle_active)
        else $error("run strobe without run test");
    cap_single_a: assert property (
        strobe.capture_dr |-> cap_pulse)
        else $error("capture strobe not a single pulse");
    tdo_fall_a: assert property (
        $changed(tdo) |-> !tck)
        else $error("tdo moved while tck high");
    oe_fall_a: assert property (
        $changed(tdo_oe) |-> !tck)
        else $error("tdo enable moved while tck high");
    upd_fall_a: assert property (
        strobe.update_dr |-> !tck && !strobe.capture_dr)
        else $error("update strobe off the falling edge");
endmodule

bind stir_core stir_core_sva i_sva (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .chain_so(chain_so), .a_side_drive_enable(a_side_drive_enable),
    .b_side_drive_enable(b_side_drive_enable), .tdo(tdo), .tdo_oe(tdo_oe), .ctl(ctl),
    .strobe(strobe));

// ==== dv/stir_host_model.sv ====
`timescale 1ns/1ps
module stir_host_model (
    input wire logic sys_clk, // system clock
    input wire logic tdo, // test data from the device
    output logic tck, // test clock, still between frames
    output logic tms, // mode select
    output logic tdi // test data to the device
);
    // idle lines at time zero
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 160 ns tck period; tdo is read just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge sys_clk);
        tms <= m;
        tdi <= d;
        repeat (7) @(posedge sys_clk);
        q = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge sys_clk);
        tck <= 1'b0;
        tdi <= ~d; // released line shows no stale value
    endtask

    // five high mode selects reach test-logic-reset, then idle
    task automatic reset_tap();
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // instruction or data scan from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [15:0] v,
                        output logic [15:0] q);
        logic b;
        q = 16'h0000;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

// ==== dv/stir_core_tb.sv ====
`timescale 1ns/1ps
module stir_core_tb import stir_pkg::*; ;
    logic sys_clk, reset, tck, tms, tdi, chain_so, tdo, tdo_oe, bit_v;
    logic a_side_drive_enable, b_side_drive_enable;
    wire logic tdo_line = tdo_oe ? tdo : ~tdo; // released tdo reads inverted
    stir_ctl_t ctl;
    stir_strobe_t strobe;
    logic [15:0] got, prev, v;
    logic [7:0] op;
    logic [8:0] want;
    int seed = 32'h1a4e;
    int fail_count = 0;
    int checks_done = 0;
    int ticks = 0;
    logic [7:0] codes [13] = '{OPC_EXTEST_ZERO, OPC_BYPASS, OPC_SAMPLE, OPC_EXTEST, OPC_HIGHZ,
        OPC_CLAMP, OPC_RUN_TEST, OPC_READ_NORMAL, OPC_READ_TEST, OPC_CELL_CHECK,
        OPC_TOGGLE_OUT, OPC_CTRL_NORMAL, OPC_CTRL_TEST};

    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;

    stir_core i_dut (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .chain_so(chain_so), .a_side_drive_enable(a_side_drive_enable),
        .b_side_drive_enable(b_side_drive_enable), .tdo(tdo), .tdo_oe(tdo_oe), .ctl(ctl),
        .strobe(strobe));
    stir_host_model i_host (.sys_clk(sys_clk), .tdo(tdo_line), .tck(tck), .tms(tms),
        .tdi(tdi));

    // run-test ticks seen on the chain strobes
    always @(posedge sys_clk) begin
        if (strobe.run_tick) ticks <= ticks + 1;
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // expected {chain, bypass, ctrl, test, highz, run, toggle, capture}
    function automatic logic [8:0] exp_ctl(input logic [7:0] c, input logic one_dir);
        case (c)
            OPC_EXTEST_ZERO, OPC_EXTEST: exp_ctl = 9'b100100001;
            OPC_SAMPLE: exp_ctl = 9'b100000001;
            OPC_HIGHZ: exp_ctl = 9'b010010000;
            OPC_CLAMP: exp_ctl = 9'b010100000;
            OPC_RUN_TEST: exp_ctl = one_dir ? 9'b010101000 : 9'b010000000;
            OPC_READ_NORMAL: exp_ctl = 9'b100000000;
            OPC_READ_TEST: exp_ctl = 9'b100100000;
            OPC_CELL_CHECK: exp_ctl = 9'b100000010;
            OPC_TOGGLE_OUT: exp_ctl = 9'b010100100;
            OPC_CTRL_NORMAL: exp_ctl = 9'b001000000;
            OPC_CTRL_TEST: exp_ctl = 9'b001100000;
            default: exp_ctl = 9'b010000000;
        endcase
    endfunction

    // expected run operation from the three op bits
    function automatic logic [2:0] exp_op(input logic [2:0] c);
        if (c[1:0] == 2'b00) exp_op = 3'h0;
        else if (c[1:0] == 2'b01) exp_op = 3'h1;
        else if (c[1:0] == 2'b10) exp_op = 3'h2;
        else exp_op = c[2] ? 3'h4 : 3'h3;
    endfunction

    function automatic logic [8:0] seen_ctl();
        seen_ctl = {ctl.boundary_sel, ctl.bypass_sel, ctl.ctrl_sel, ctl.test_mode, ctl.highz,
            ctl.run_active, ctl.toggle_active, ctl.boundary_sel ? ctl.cap_mode : CAP_HOLD};
    endfunction

    // instruction load, checking the captured status on the way out
    task automatic ldir(input logic [7:0] c);
        i_host.scan(1'b1, 8, {8'h00, c}, got);
        check(got & 16'h00ff, {8'h00, IR_CAPTURE});
    endtask

    // bound on the whole run
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        chain_so = 1'b0;
        a_side_drive_enable = 1'b1;
        b_side_drive_enable = 1'b0;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({4'h0, ctl.bypass_sel, ctl.run_op, ctl.input_mask}, {5'h01, 3'h2, 8'h00});
        i_host.reset_tap();
        // bypass stage captures 0 ahead of the shifted-in bit
        ldir(OPC_BYPASS);
        i_host.scan(1'b0, 2, 16'h0001, got);
        check(got & 16'h0003, 16'h0002);
        $display("bypass test done");
        // listed opcodes, then random opcodes of either parity
        for (int i = 0; i < 19; i++) begin
            op = (i < 13) ? codes[i] : 8'($random(seed));
            ldir(op);
            want = exp_ctl(op, 1'b1);
            check({7'h00, seen_ctl()}, {7'h00, want});
            if (want[8]) begin
                bit_v = 1'($random(seed));
                chain_so <= bit_v;
                i_host.scan(1'b0, 4, 16'h0005, got);
                check(got & 16'h000f, {12'h000, {4{bit_v}}});
            end
        end
        $display("opcode test done");
        // control scans return the previous contents and decode op and masks
        prev = 16'h0002;
        ldir(OPC_CTRL_NORMAL);
        for (int c = 0; c < 8; c++) begin
            v = {5'h00, 8'($random(seed)), 3'(c)};
            if (c == 7) ldir(OPC_CTRL_TEST);
            i_host.scan(1'b0, 11, v, got);
            check(got, prev);
            got = {5'h00, ctl.input_mask, ctl.run_op};
            check(got, {5'h00, v[10:3], exp_op(v[2:0])});
            prev = v;
        end
        $display("control register test done");
        // operation loaded before run test, then both directions enabled
        ldir(OPC_CTRL_NORMAL);
        i_host.scan(1'b0, 11, 16'h0003, got);
        ldir(OPC_RUN_TEST);
        check({7'h00, seen_ctl()}, {7'h00, exp_ctl(OPC_RUN_TEST, 1'b1)});
        check({13'h0000, ctl.run_op}, 16'h0003);
        prev = 16'(ticks);
        repeat (4) i_host.step(1'b0, 1'b0, bit_v);
        b_side_drive_enable <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({7'h00, seen_ctl()}, {7'h00, exp_ctl(OPC_RUN_TEST, 1'b0)});
        check(16'(ticks) - prev, 16'h0004);
        $display("run test done");
        // test-logic-reset restores bypass and the control register
        i_host.reset_tap();
        check({15'h0000, ctl.bypass_sel}, 16'h0001);
        ldir(OPC_CTRL_NORMAL);
        i_host.scan(1'b0, 11, 16'h0000, got);
        check(got, 16'h0002);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
